// File: design/sram_host.sv
`timescale 1ns/100ps
`default_nettype none
module sram_host
  import sram_host_pkg::*;
#(
  parameter int unsigned POWER_CYCLES = POWER_UP_CYCLES
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire logic                              req_write,
  input  wire logic [sram_host_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [sram_host_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic [1:0]                        req_lanes,
  output logic                                   rsp_valid,
  output logic      [sram_host_pkg::DATA_W-1:0]  rsp_rdata,
  output logic      [sram_host_pkg::ADDR_W-1:0]  mem_addr,
  output logic                                   chip_sel_n,
  output logic                                   write_n,
  output logic                                   out_drive_n,
  output logic                                   low_byte_lane_n,
  output logic                                   high_byte_lane_n,
  input  wire logic [sram_host_pkg::DATA_W-1:0]  mem_dq_in,
  output logic      [sram_host_pkg::DATA_W-1:0]  mem_dq_out,
  output logic      [sram_host_pkg::DATA_W-1:0]  mem_dq_oe
);
  import sram_host_pkg::*;

  // Wait counter compare; used by several states. The counter starts
  // at zero on entry, so a wait of n cycles ends when it reaches n-1.
  function automatic logic cnt_done(input logic [CNT_W-1:0] c,
                                    input int unsigned n);
    cnt_done = (c >= CNT_W'(n - 1));
  endfunction

  // Registered state
  seq_state_e              state_ff, nxt_state;      // Sequencer
  logic [CNT_W-1:0]        cnt_ff, nxt_cnt;          // Cycle counter
  logic                    wr_ff, nxt_wr;            // Access is a write
  logic [1:0]              lanes_ff, nxt_lanes;      // Lane enables, high
  logic [ADDR_W-1:0]       addr_ff, nxt_addr;        // Address pins
  logic [DATA_W-1:0]       wdata_ff, nxt_wdata;      // Write data
  logic                    cs_n_ff, nxt_cs_n;        // Chip select pin
  logic                    we_n_ff, nxt_we_n;        // Write strobe pin
  logic                    oe_n_ff, nxt_oe_n;        // Output drive pin
  logic                    dq_en_ff, nxt_dq_en;      // Host drives bus
  logic                    rsp_ff, nxt_rsp;          // Read answer pulse
  logic [DATA_W-1:0]       rdata_ff, nxt_rdata;      // Read answer data

  // Only accept work once the power wait is over and idle
  // Combinational, so a waiting request is taken on the first idle edge
  assign req_ready = (state_ff == ST_IDLE);

  // One access walks IDLE, SETUP, then WRITE or READ, then HOLD.
  // SETUP gives the address a full cycle before select falls, so the
  // device never sees a moving address while it is selected.
  // HOLD keeps address and write data on the pins one cycle after the
  // strobes rise, which covers any hold the device might want.
  // Limitation: the data pins are sampled without a synchroniser; the
  // read is safe only because the device has settled for several
  // cycles before the sample edge. A slower part needs READ_CYCLES
  // raised in the package.
  // Next-value logic for the sequencer and pins
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + CNT_W'(1);
    nxt_wr    = wr_ff;
    nxt_lanes = lanes_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_cs_n  = cs_n_ff;
    nxt_we_n  = we_n_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_dq_en = dq_en_ff;
    nxt_rsp   = 1'b0;
    nxt_rdata = rdata_ff;
    // Defaults above hold every pin; states change only what they own
    case (state_ff)
      ST_POWER: begin
        // Count out the wait before the first access
        if (cnt_done(cnt_ff, POWER_CYCLES)) begin
          nxt_state = ST_IDLE;
          nxt_cnt   = '0;
        end
      end
      ST_IDLE: begin
        nxt_cnt = '0;
        // Deselected while idle, so the device sits in standby
        nxt_cs_n = 1'b1;
        // Request taken here; the sequencer is busy from the next cycle
        if (req_valid) begin
          // Whole address latched first, select follows later
          nxt_addr  = req_addr;
          nxt_wr    = req_write;
          nxt_lanes = req_lanes;
          nxt_wdata = req_wdata;
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Address has been stable a cycle; now assert strobes
        nxt_cs_n  = 1'b0;
        nxt_cnt   = '0;
        if (wr_ff) begin
          // Write: output drive kept high, host drives the bus
          nxt_we_n  = 1'b0;
          nxt_oe_n  = 1'b1;
          nxt_dq_en = 1'b1;
          nxt_state = ST_WRITE;
        end else begin
          // Read: write strobe high, host releases the bus
          nxt_we_n  = 1'b1;
          nxt_oe_n  = 1'b0;
          nxt_dq_en = 1'b0;
          nxt_state = ST_READ;
        end
      end
      ST_WRITE: begin
        // Write strobe held low for STROBE_CYCLES
        if (cnt_done(cnt_ff, STROBE_CYCLES)) begin
          // Write ends on write strobe rising; select rises with it,
          // address and data held one more cycle after the end
          nxt_we_n  = 1'b1;
          nxt_cs_n  = 1'b1;
          nxt_state = ST_HOLD;
        end
      end
      ST_READ: begin
        // Strobes held for READ_CYCLES, then the bus is sampled
        if (cnt_done(cnt_ff, READ_CYCLES)) begin
          // Disabled lanes read as zero; device leaves them floating
          nxt_rdata = { lanes_ff[1] ? mem_dq_in[DATA_W-1:BYTE_W]
                                    : {BYTE_W{1'b0}},
                        lanes_ff[0] ? mem_dq_in[BYTE_W-1:0]
                                    : {BYTE_W{1'b0}} };
          nxt_rsp   = 1'b1;
          nxt_oe_n  = 1'b1;
          nxt_cs_n  = 1'b1;
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Release the bus only after strobes are already high
        nxt_dq_en = 1'b0;
        nxt_state = ST_IDLE;
      end
      default: begin
        // Unreachable codes fall back to idle
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Synchronous reset puts every strobe high and the bus released
  // Register all state; pins come straight from flip-flops, except lane enables and bus enables, which pass through one gate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // Deselected, strobes high, host off the bus
      state_ff <= ST_POWER;
      cnt_ff   <= '0;
      wr_ff    <= 1'b0;
      lanes_ff <= 2'h0;
      addr_ff  <= ADDR_RST;
      wdata_ff <= DATA_RST;
      cs_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      dq_en_ff <= 1'b0;
      rsp_ff   <= 1'b0;
      rdata_ff <= DATA_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      wr_ff    <= nxt_wr;
      lanes_ff <= nxt_lanes;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      cs_n_ff  <= nxt_cs_n;
      we_n_ff  <= nxt_we_n;
      oe_n_ff  <= nxt_oe_n;
      dq_en_ff <= nxt_dq_en;
      rsp_ff   <= nxt_rsp;
      rdata_ff <= nxt_rdata;
    end
  end

  // Lane enables are active only while selected, so an idle bus
  // never presents stray lane strobes
  assign low_byte_lane_n  = cs_n_ff | ~lanes_ff[0];
  assign high_byte_lane_n = cs_n_ff | ~lanes_ff[1];

  // Pin outputs
  // Address, select, write and output drive straight from flip-flops, so they never glitch
  assign mem_addr    = addr_ff;
  assign chip_sel_n  = cs_n_ff;
  assign write_n     = we_n_ff;
  assign out_drive_n = oe_n_ff;
  assign mem_dq_out  = wdata_ff;
  // Only enabled lanes are driven; the others stay undriven
  assign mem_dq_oe   = { {BYTE_W{dq_en_ff & lanes_ff[1]}},
                         {BYTE_W{dq_en_ff & lanes_ff[0]}} };
  assign rsp_valid   = rsp_ff;
  assign rsp_rdata   = rdata_ff;
endmodule // sram_host
`default_nettype wire

// File: design/sram_host_pkg.sv
package sram_host_pkg;
  // Geometry of the memory
  localparam int ADDR_W    = 17;          // Word address width
  localparam int DATA_W    = 16;          // Word width
  localparam int BYTE_W    = 8;           // Lane width
  localparam int WORDS     = 131072;      // Words in the memory

  // Timing at 200 MHz
  localparam int CLK_PERIOD_PS     = 5000;       // Clock period in ps
  localparam int POWER_UP_WAIT_US  = 1;          // Least wait after power
  localparam int POWER_UP_CYCLES   =
    (POWER_UP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CYCLES      = 1;          // Address before strobe
  localparam int STROBE_CYCLES     = 2;          // Strobe low, 10 ns
  localparam int READ_CYCLES       = 3;          // Output drive low, 15 ns
  localparam int CNT_W             = 16;         // Wait counter width

  // Reset values of the pins
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_POWER = 6'h01,
    ST_IDLE  = 6'h02,
    ST_SETUP = 6'h04,
    ST_WRITE = 6'h08,
    ST_READ  = 6'h10,
    ST_HOLD  = 6'h20
  } seq_state_e;
endpackage : sram_host_pkg

// File: bench/sram_host_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sram_host_monitor
  import sram_host_pkg::*;
#(
  parameter int unsigned POWER_CYCLES = POWER_UP_CYCLES  // Power wait
) (
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  input  wire logic                             req_ready,
  input  wire logic                             rsp_valid,
  input  wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                             chip_sel_n,
  input  wire logic                             write_n,
  input  wire logic                             out_drive_n,
  input  wire logic                             low_byte_lane_n,
  input  wire logic                             high_byte_lane_n,
  input  wire logic [sram_host_pkg::DATA_W-1:0] mem_dq_out,
  input  wire logic [sram_host_pkg::DATA_W-1:0] mem_dq_oe
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles since reset ended, held at its top value
  logic [CNT_W-1:0] pw_cnt_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) pw_cnt_ff <= '0;
    else if (pw_cnt_ff != '1) pw_cnt_ff <= pw_cnt_ff + CNT_W'(1);
  end
  wr_select_a: assert property (
    !write_n |-> !chip_sel_n && out_drive_n)
    else $error("write strobe without select");
  rd_strobes_a: assert property (
    !out_drive_n |-> write_n && !chip_sel_n)
    else $error("read strobes wrong");
  rd_no_drive_a: assert property (
    !out_drive_n |-> mem_dq_oe == '0)
    else $error("host drives bus in read");
  lane_drive_a: assert property (
    !write_n |-> mem_dq_oe ==
    {{BYTE_W{!high_byte_lane_n}}, {BYTE_W{!low_byte_lane_n}}})
    else $error("write drive does not match lanes");
  addr_setup_a: assert property (
    $fell(chip_sel_n) |-> $stable(mem_addr))
    else $error("address moved at select");
  addr_hold_a: assert property (
    !chip_sel_n |=> $stable(mem_addr))
    else $error("address moved in access");
  data_hold_a: assert property (
    $rose(write_n) |-> $stable(mem_dq_out)
    && mem_dq_oe == $past(mem_dq_oe))
    else $error("data dropped at write end");
  we_width_a: assert property (
    $fell(write_n) |=> !write_n ##1 write_n && chip_sel_n)
    else $error("write pulse wrong");
  rd_answer_a: assert property (
    $fell(out_drive_n) |-> ##3 rsp_valid)
    else $error("read answer late");
  power_wait_a: assert property (
    req_ready |-> pw_cnt_ff >= CNT_W'(POWER_CYCLES))
    else $error("ready before power wait");
endmodule // sram_host_monitor
bind sram_host sram_host_monitor #(.POWER_CYCLES(POWER_CYCLES)) i_mon (.*);
`default_nettype wire

// File: bench/sram_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module sram_dev_model
  import sram_host_pkg::*;
(
  input  wire logic                             chip_sel_n,
  input  wire logic                             write_n,
  input  wire logic                             out_drive_n,
  input  wire logic                             low_byte_lane_n,
  input  wire logic                             high_byte_lane_n,
  input  wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [sram_host_pkg::DATA_W-1:0] mem_dq_in,
  output logic      [sram_host_pkg::DATA_W-1:0] dev_dq_out,
  output logic      [sram_host_pkg::DATA_W-1:0] dev_dq_oe
);
  logic [DATA_W-1:0] mem [WORDS];  // Word store
  logic              rd;           // Read mode from the strobe truth table
  // Deselect, write or output disable all leave the bus undriven
  assign rd = !chip_sel_n && !out_drive_n
              && write_n;
  assign dev_dq_oe = {
                      {BYTE_W{rd && !high_byte_lane_n}},
                      {BYTE_W{rd && !low_byte_lane_n}}};
  assign dev_dq_out = mem[mem_addr];
  // Store follows the bus while write is open, so the last value wins
  always @* begin
    if (!chip_sel_n && !write_n) begin
      if (!low_byte_lane_n) mem[mem_addr][7:0] = mem_dq_in[7:0];
      if (!high_byte_lane_n) mem[mem_addr][15:8] = mem_dq_in[15:8];
    end
  end
endmodule // sram_dev_model
`default_nettype wire

// File: bench/sram_host_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sram_host_bench;
  import sram_host_pkg::*;
  logic clk_sys, rst, req_valid, req_write, req_ready, rsp_valid;
  logic chip_sel_n, write_n, out_drive_n, low_byte_lane_n, high_byte_lane_n;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_dq_in, mem_dq_out, q;
  logic [DATA_W-1:0] mem_dq_oe, dev_dq_out, dev_dq_oe;
  logic [1:0]        req_lanes;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  localparam int unsigned PW_WAIT = 4;  // Short power wait for simulation
  sram_host #(.POWER_CYCLES(PW_WAIT)) i_sram_host (.*);
  sram_dev_model i_sram_dev_model (.*);
  // Released lines float to a pattern that changes every cycle
  assign mem_dq_in = (mem_dq_oe & mem_dq_out) | (dev_dq_oe & dev_dq_out)
    | (~mem_dq_oe & ~dev_dq_oe & (16'hA5A5 ^ 16'(cyc)));
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(string nm, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Both parties driving one line is a fight; looked at mid-cycle
  always @(negedge clk_sys)
    if (!rst) chk("bus_fight", 16'h0000, mem_dq_oe & dev_dq_oe);
  // Hang guard on cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  // One request, held until taken; a read waits for its answer in q
  task automatic access(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
                        logic [1:0] l);
    int n;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= l;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 40);
    chk("req_ready", 16'h0001, 16'(req_ready));
    @(posedge clk_sys);
    req_valid <= 1'b0;
    n = 0;
    if (!w) begin
      do begin @(negedge clk_sys); n++; end
        while (rsp_valid !== 1'b1 && n < 10);
      chk("rsp_valid", 16'h0001, 16'(rsp_valid));
      chk("read_wait", 16'(SETUP_CYCLES + READ_CYCLES + 1), 16'(n));
    end
    q = rsp_rdata;
    @(posedge clk_sys);
  endtask
  task automatic t_power;
    repeat (PW_WAIT) begin
      @(negedge clk_sys);
      chk("ready_early", 16'h0000, 16'(req_ready));
    end
    @(negedge clk_sys);
    chk("ready_late", 16'h0001, 16'(req_ready));
    @(posedge clk_sys);
  endtask
  task automatic t_top_word;
    access(1'b1, 17'h1FFFF, 16'hBEEF, 2'h3);
    access(1'b0, 17'h1FFFF, 16'h0000, 2'h3);
    chk("top_word", 16'hBEEF, q);
  endtask
  task automatic t_lane_writes;
    access(1'b1, 17'h00000, 16'h1234, 2'h3);
    access(1'b1, 17'h00000, 16'hA5CD, 2'h1);
    access(1'b0, 17'h00000, 16'h0000, 2'h3);
    chk("low_write", 16'h12CD, q);
    access(1'b1, 17'h00000, 16'h7799, 2'h2);
    access(1'b0, 17'h00000, 16'h0000, 2'h3);
    chk("high_write", 16'h77CD, q);
  endtask
  task automatic t_lane_reads;
    access(1'b0, 17'h00000, 16'h0000, 2'h1);
    chk("low_read", 16'h00CD, q);
    access(1'b0, 17'h00000, 16'h0000, 2'h2);
    chk("high_read", 16'h7700, q);
    access(1'b1, 17'h00000, 16'hFFFF, 2'h0);
    access(1'b0, 17'h00000, 16'h0000, 2'h3);
    chk("no_lane_write", 16'h77CD, q);
    access(1'b0, 17'h00000, 16'h0000, 2'h0);
    chk("no_lane_read", 16'h0000, q);
  endtask
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 17'h00000;
    req_wdata = 16'h0000;
    req_lanes = 2'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_power();
    t_top_word();
    t_lane_writes();
    t_lane_reads();
    close_out();
  end
endmodule // sram_host_bench
`default_nettype wire
